// *** hdl/ipr_regs.sv ***
// Interrupt priority register bank: three words of four priority fields.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ipr_regs
  import ipr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [15:0] rd_data,
  output logic [2:0] uart_one_receive_priority,
  output logic [2:0] spi_one_transfer_priority,
  output logic [2:0] spi_one_general_priority,
  output logic [2:0] timer_three_priority,
  output logic [2:0] flash_program_done_priority,
  output logic [2:0] dma_channel_one_priority,
  output logic [2:0] adc_priority,
  output logic [2:0] uart_one_transmit_priority,
  output logic [2:0] pin_change_priority,
  output logic [2:0] comparator_priority,
  output logic [2:0] i2c_one_host_priority,
  output logic [2:0] i2c_one_client_priority
);

  localparam int NUM_FIELDS = IPR_NUM_REGS * IPR_SLOTS;

  ipr_regs_s state;
  ipr_regs_s next_state;
  logic [2:0] lvl [NUM_FIELDS];
  logic [IPR_NUM_REGS-1:0] wr_hit;

  // Decode which word a write strobe lands on; unmapped writes vanish.
  // Only exact byte offsets match, so an odd offset never aliases a word.
  always_comb begin
    for (int r = 0; r < IPR_NUM_REGS; r++) begin
      wr_hit[r] = wr_strobe && (addr == IPR_OFS[r]);
    end
  end

  // One field per source; the field index runs word by word, high slot
  // first, so the index order matches the order of the output ports.
  for (genvar gi = 0; gi < NUM_FIELDS; gi++) begin : g_field
    localparam int REG = gi / IPR_SLOTS;
    localparam int LSB = IPR_SLOT_LSB[gi % IPR_SLOTS];
    ipr_field #(
      .RESET_LEVEL(IPR_LEVEL_RESET)
    ) u_field (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .wr_en(wr_hit[REG]),
      .wr_level(wr_data[LSB +: IPR_LEVEL_W]),
      .level(lvl[gi])
    );
  end

  // Read data stand for one cycle after the strobe and are zero otherwise,
  // so a stale word never looks like a fresh answer. Unused bits are never
  // stored, which keeps writes to them harmless without a mask register.
  always_comb begin
    next_state = state;
    next_state.fresh = 1'b0;
    next_state.rd_data = '0;
    if (rd_strobe) begin
      for (int r = 0; r < IPR_NUM_REGS; r++) begin
        if (addr == IPR_OFS[r]) begin
          for (int s = 0; s < IPR_SLOTS; s++) begin
            next_state.rd_data[IPR_SLOT_LSB[s] +: IPR_LEVEL_W] =
              lvl[r * IPR_SLOTS + s];
          end
        end
      end
    end
    next_state.rd_data = next_state.rd_data & IPR_IMPL_MASK;
  end

  // Register the bank state; fresh marks the first cycle out of reset.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state.rd_data <= '0;
      state.fresh <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Read data come straight from the registered read word.
  assign rd_data = state.rd_data;

  // First word: receive, transfer, general and timer levels.
  assign uart_one_receive_priority = lvl[0];
  assign spi_one_transfer_priority = lvl[1];
  assign spi_one_general_priority = lvl[2];
  assign timer_three_priority = lvl[3];

  // Second word: flash, DMA, converter and transmit levels.
  assign flash_program_done_priority = lvl[4];
  assign dma_channel_one_priority = lvl[5];
  assign adc_priority = lvl[6];
  assign uart_one_transmit_priority = lvl[7];

  // Third word: pin change, comparator and both I2C event levels.
  assign pin_change_priority = lvl[8];
  assign comparator_priority = lvl[9];
  assign i2c_one_host_priority = lvl[10];
  assign i2c_one_client_priority = lvl[11];

  // Checks below all run on the one clock and are muted under reset.
  // Reset mutes them because every field jumps to its default there.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // Field positions by slot, taken from the shared table so the checks
  // and the datapath can never disagree on where a level sits.
  localparam int S0 = IPR_SLOT_LSB[0];
  localparam int S1 = IPR_SLOT_LSB[1];
  localparam int S2 = IPR_SLOT_LSB[2];
  localparam int S3 = IPR_SLOT_LSB[3];

  logic wa;
  logic wb;
  logic wc;
  assign wa = wr_strobe && addr == IPR_OFS_UART_RX_SPI_TIMER;
  assign wb = wr_strobe && addr == IPR_OFS_NVM_DMA_ADC_UART_TX;
  assign wc = wr_strobe && addr == IPR_OFS_CHANGE_COMPARATOR_I2C;

  // Every source leaves reset at the default level.
  chk_reset_level: assert property (
    state.fresh |-> (uart_one_receive_priority == IPR_LEVEL_RESET &&
      spi_one_transfer_priority == IPR_LEVEL_RESET &&
      spi_one_general_priority == IPR_LEVEL_RESET &&
      timer_three_priority == IPR_LEVEL_RESET &&
      flash_program_done_priority == IPR_LEVEL_RESET &&
      dma_channel_one_priority == IPR_LEVEL_RESET &&
      adc_priority == IPR_LEVEL_RESET &&
      uart_one_transmit_priority == IPR_LEVEL_RESET &&
      pin_change_priority == IPR_LEVEL_RESET &&
      comparator_priority == IPR_LEVEL_RESET &&
      i2c_one_host_priority == IPR_LEVEL_RESET &&
      i2c_one_client_priority == IPR_LEVEL_RESET))
    else $error("Priority field not at default level after reset.");

  // The receive and general levels hold until a write reaches the first word.
  chk_level_holds: assert property (
    !wa |=> $stable(spi_one_general_priority) &&
      $stable(uart_one_receive_priority))
    else $error("Priority level changed without a write.");

  // Each word holds while no write lands on it. Without these a stray
  // decode could move a level silently, and no read would show it until
  // software happened to look.
  chk_hold_word_a: assert property (
    !wa |=> $stable(uart_one_receive_priority) &&
      $stable(spi_one_transfer_priority) &&
      $stable(spi_one_general_priority) &&
      $stable(timer_three_priority))
    else $error("First word changed without a write to it.");

  // The second word holds while no write lands on it.
  chk_hold_word_b: assert property (
    !wb |=> $stable(flash_program_done_priority) &&
      $stable(dma_channel_one_priority) &&
      $stable(adc_priority) &&
      $stable(uart_one_transmit_priority))
    else $error("Second word changed without a write to it.");

  // The third word holds while no write lands on it.
  chk_hold_word_c: assert property (
    !wc |=> $stable(pin_change_priority) &&
      $stable(comparator_priority) &&
      $stable(i2c_one_host_priority) &&
      $stable(i2c_one_client_priority))
    else $error("Third word changed without a write to it.");

  // A read gives back each level unchanged, so order is numeric.
  chk_read_back: assert property (
    (rd_strobe && addr == IPR_OFS_NVM_DMA_ADC_UART_TX) |=>
      rd_data == {1'b0, $past(flash_program_done_priority),
        1'b0, $past(dma_channel_one_priority),
        1'b0, $past(adc_priority),
        1'b0, $past(uart_one_transmit_priority)})
    else $error("Read word does not match the stored levels.");

  // The first word reads back as its four levels with zero gaps.
  chk_read_back_a: assert property (
    (rd_strobe && addr == IPR_OFS_UART_RX_SPI_TIMER) |=>
      rd_data == {1'b0, $past(uart_one_receive_priority),
        1'b0, $past(spi_one_transfer_priority),
        1'b0, $past(spi_one_general_priority),
        1'b0, $past(timer_three_priority)})
    else $error("First word read does not match its levels.");

  // The third word reads back as its four levels with zero gaps.
  chk_read_back_c: assert property (
    (rd_strobe && addr == IPR_OFS_CHANGE_COMPARATOR_I2C) |=>
      rd_data == {1'b0, $past(pin_change_priority),
        1'b0, $past(comparator_priority),
        1'b0, $past(i2c_one_host_priority),
        1'b0, $past(i2c_one_client_priority)})
    else $error("Third word read does not match its levels.");

  // Writes to the first word land in its four fields.
  chk_wr_uart_rx: assert property (
    wa |=> uart_one_receive_priority == $past(wr_data[S0 +: 3]))
    else $error("UART receive priority not written.");

  chk_wr_spi_xfer: assert property (
    wa |=> spi_one_transfer_priority == $past(wr_data[S1 +: 3]))
    else $error("SPI transfer priority not written.");

  chk_wr_spi_gen: assert property (
    wa |=> spi_one_general_priority == $past(wr_data[S2 +: 3]))
    else $error("SPI general priority not written.");

  chk_wr_timer: assert property (
    wa |=> timer_three_priority == $past(wr_data[S3 +: 3]))
    else $error("Timer priority not written.");

  // Writes to the second word land in its four fields.
  chk_wr_flash: assert property (
    wb |=> flash_program_done_priority == $past(wr_data[S0 +: 3]))
    else $error("Flash done priority not written.");

  chk_wr_dma: assert property (
    wb |=> dma_channel_one_priority == $past(wr_data[S1 +: 3]))
    else $error("DMA priority not written.");

  chk_wr_adc: assert property (
    wb |=> adc_priority == $past(wr_data[S2 +: 3]))
    else $error("ADC priority not written.");

  chk_wr_uart_tx: assert property (
    wb |=> uart_one_transmit_priority == $past(wr_data[S3 +: 3]))
    else $error("UART transmit priority not written.");

  // Writes to the third word land in its four fields.
  chk_wr_change: assert property (
    wc |=> pin_change_priority == $past(wr_data[S0 +: 3]))
    else $error("Pin change priority not written.");

  chk_wr_comparator: assert property (
    wc |=> comparator_priority == $past(wr_data[S1 +: 3]))
    else $error("Comparator priority not written.");

  chk_wr_i2c_host: assert property (
    wc |=> i2c_one_host_priority == $past(wr_data[S2 +: 3]))
    else $error("I2C host priority not written.");

  chk_wr_i2c_client: assert property (
    wc |=> i2c_one_client_priority == $past(wr_data[S3 +: 3]))
    else $error("I2C client priority not written.");

  // Gaps in every word read as zero, and other addresses read as zero.
  chk_gap_bits: assert property (
    (rd_data & ~IPR_IMPL_MASK) == 16'h0000)
    else $error("Unimplemented read bit is set.");

  chk_unmapped_read: assert property (
    (rd_strobe && addr != IPR_OFS_UART_RX_SPI_TIMER &&
      addr != IPR_OFS_NVM_DMA_ADC_UART_TX &&
      addr != IPR_OFS_CHANGE_COMPARATOR_I2C) |=> rd_data == 16'h0000)
    else $error("Unmapped read returned data.");

  // A write to an offset outside the map moves no level at all.
  chk_unmapped_write: assert property (
    (wr_strobe && !wa && !wb && !wc) |=>
      $stable(uart_one_receive_priority) &&
      $stable(spi_one_transfer_priority) &&
      $stable(spi_one_general_priority) &&
      $stable(timer_three_priority) &&
      $stable(flash_program_done_priority) &&
      $stable(dma_channel_one_priority) &&
      $stable(adc_priority) &&
      $stable(uart_one_transmit_priority) &&
      $stable(pin_change_priority) &&
      $stable(comparator_priority) &&
      $stable(i2c_one_host_priority) &&
      $stable(i2c_one_client_priority))
    else $error("Unmapped write moved a priority level.");

  // Read data last one cycle only.
  chk_read_one_cycle: assert property (
    !rd_strobe |=> rd_data == 16'h0000)
    else $error("Read data stood without a read strobe.");

  // Writing to the first word leaves the flash and pin change levels alone.
  chk_word_isolation: assert property (
    (wa && !wc) |=> $stable(pin_change_priority) [*1] ##0
      $stable(flash_program_done_priority))
    else $error("Write to one word disturbed another.");

  // A read straight after a write to the first word sees the new word.
  chk_wr_rd_word_a: assert property (
    wa ##1 (rd_strobe && addr == IPR_OFS_UART_RX_SPI_TIMER) |=>
      rd_data == ($past(wr_data, 2) & IPR_IMPL_MASK))
    else $error("Read after write missed the first word.");

  // A read straight after a write to the second word sees the new word.
  chk_wr_rd_word_b: assert property (
    wb ##1 (rd_strobe && addr == IPR_OFS_NVM_DMA_ADC_UART_TX) |=>
      rd_data == ($past(wr_data, 2) & IPR_IMPL_MASK))
    else $error("Read after write missed the second word.");

  // A read straight after a write to the third word sees the new word.
  chk_wr_rd_word_c: assert property (
    wc ##1 (rd_strobe && addr == IPR_OFS_CHANGE_COMPARATOR_I2C) |=>
      rd_data == ($past(wr_data, 2) & IPR_IMPL_MASK))
    else $error("Read after write missed the third word.");

  // Main scenarios.
  cov_write_max: cover property (
    wa && wr_data[S0 +: 3] == IPR_LEVEL_MAX);
  cov_write_min: cover property (
    wc && wr_data[S3 +: 3] == IPR_LEVEL_MIN);
  cov_write_then_read: cover property (
    wb ##1 (rd_strobe && addr == IPR_OFS_NVM_DMA_ADC_UART_TX));
  cov_read_after_reset: cover property (
    state.fresh ##1 (rd_strobe && addr == IPR_OFS_UART_RX_SPI_TIMER));
  cov_unmapped_write: cover property (
    wr_strobe && !wa && !wb && !wc);

endmodule
`default_nettype wire

// *** inc/ipr_pkg.sv ***
// Constants and types shared by the interrupt priority register bank.
`default_nettype none
package ipr_pkg;

  // Register port geometry.
  localparam int IPR_ADDR_W = 8;
  localparam int IPR_DATA_W = 16;
  localparam int IPR_LEVEL_W = 3;
  localparam int IPR_NUM_REGS = 3;
  localparam int IPR_SLOTS = 4;

  // Register offsets as seen on the address port.
  localparam logic [7:0] IPR_OFS_UART_RX_SPI_TIMER = 8'hac;
  localparam logic [7:0] IPR_OFS_NVM_DMA_ADC_UART_TX = 8'hae;
  localparam logic [7:0] IPR_OFS_CHANGE_COMPARATOR_I2C = 8'hb0;
  localparam logic [7:0] IPR_OFS [IPR_NUM_REGS] = '{
    IPR_OFS_UART_RX_SPI_TIMER,
    IPR_OFS_NVM_DMA_ADC_UART_TX,
    IPR_OFS_CHANGE_COMPARATOR_I2C
  };

  // Low bit of each field, slot 0 being the highest field of a word.
  localparam int IPR_SLOT_LSB [IPR_SLOTS] = '{12, 8, 4, 0};

  // Level encoding and reset value of every field.
  localparam logic [2:0] IPR_LEVEL_MIN = 3'h0;
  localparam logic [2:0] IPR_LEVEL_MAX = 3'h7;
  localparam logic [2:0] IPR_LEVEL_RESET = 3'h4;

  // Bits that hold a field; the rest read as zero.
  localparam logic [15:0] IPR_IMPL_MASK = 16'h7777;

  // State of one priority field.
  typedef struct packed {
    logic [2:0] level;
  } ipr_field_s;

  // State of the register bank top.
  typedef struct packed {
    logic [15:0] rd_data;
    logic fresh;
  } ipr_regs_s;

endpackage
`default_nettype wire

// *** hdl/ipr_field.sv ***
// One software-writable 3-bit interrupt priority field.
`timescale 1ns/100ps
`default_nettype none
module ipr_field
  import ipr_pkg::*;
#(
  parameter logic [2:0] RESET_LEVEL = IPR_LEVEL_RESET
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [2:0] wr_level,
  output logic [2:0] level
);

  ipr_field_s state;
  ipr_field_s next_state;

  // A write replaces the level whole; otherwise it holds.
  always_comb begin
    next_state = state;
    if (wr_en) begin
      next_state.level = wr_level;
    end
  end

  // Reset parks the source at the default mid level.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state.level <= RESET_LEVEL;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.level;

endmodule
`default_nettype wire

// *** test/tb_ipr_regs.sv ***
// Self-checking testbench for the interrupt priority register bank.
`timescale 1ns/100ps
`default_nettype none
module tb_ipr_regs
  import ipr_pkg::*;
;
  logic sys_clk;
  logic rstn;
  logic [7:0] addr;
  logic [15:0] wr_data;
  logic wr_strobe;
  logic rd_strobe;
  logic [15:0] rd_data;
  wire logic [2:0] lvl [12];
  wire logic [15:0] fw [3];
  int miscompares;
  int n_checks;
  int cycles;

  ipr_regs u_dut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .addr(addr),
    .wr_data(wr_data),
    .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe),
    .rd_data(rd_data),
    .uart_one_receive_priority(lvl[0]),
    .spi_one_transfer_priority(lvl[1]),
    .spi_one_general_priority(lvl[2]),
    .timer_three_priority(lvl[3]),
    .flash_program_done_priority(lvl[4]),
    .dma_channel_one_priority(lvl[5]),
    .adc_priority(lvl[6]),
    .uart_one_transmit_priority(lvl[7]),
    .pin_change_priority(lvl[8]),
    .comparator_priority(lvl[9]),
    .i2c_one_host_priority(lvl[10]),
    .i2c_one_client_priority(lvl[11])
  );

  // Field outputs packed back into register layout, so one compare covers a whole word.
  for (genvar g = 0; g < 3; g++) begin : g_pack
    assign fw[g] = {1'b0, lvl[4*g], 1'b0, lvl[4*g+1],
                    1'b0, lvl[4*g+2], 1'b0, lvl[4*g+3]};
  end

  // Free-running 125 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Cut a hang short; the whole run needs well under this many cycles.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      close_out();
    end
  end

  // Verdict and end of run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Case-equality compare so an unknown never counts as a match.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write; the strobe is left up so writes may follow back to back.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    rd_strobe <= 1'b0;
  endtask

  // One-cycle read; data is checked in the single cycle it stands.
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    wr_strobe <= 1'b0;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  // Reset held for three cycles, released on a clock edge.
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    for (int i = 0; i < 3; i++) chk(fw[i], 16'h4444);
    chk(rd_data, 16'h0000);
  endtask

  initial begin
    logic [2:0] lv;
    logic [15:0] pat [3];
    pat = '{16'h7531, 16'h0246, 16'h6420};
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    rstn = 1'b0;
    addr = 8'h00;
    wr_data = 16'h0000;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    do_reset();
    for (int i = 0; i < 3; i++) rd(IPR_OFS[i], 16'h4444);
    // All ones: the spare bits must stay zero.
    wr(IPR_OFS[0], 16'hffff);
    rd(IPR_OFS[0], 16'h7777);
    chk(fw[0], 16'h7777);
    // Back-to-back writes to every word, then all three read back in turn.
    for (int i = 0; i < 3; i++) wr(IPR_OFS[i], pat[i]);
    for (int i = 0; i < 3; i++) rd(IPR_OFS[i], pat[i]);
    for (int i = 0; i < 3; i++) chk(fw[i], pat[i]);
    // Read data stands for one cycle only.
    @(posedge sys_clk);
    #1;
    chk(rd_data, 16'h0000);
    // Every level code through every field of the third word, write then read with no gap.
    for (int i = 0; i < 8; i++) begin
      lv = i[2:0];
      wr(IPR_OFS[2], {4{1'b0, lv}});
      rd(IPR_OFS[2], {4{1'b0, lv}});
      chk(fw[2], {4{1'b0, lv}});
    end
    chk(fw[1], pat[1]);
    // Only the spare bits set: every field of the word goes to zero.
    wr(IPR_OFS[1], 16'h8888);
    rd(IPR_OFS[1], 16'h0000);
    chk(fw[1], 16'h0000);
    // Unmapped offsets between and beside the words are ignored.
    wr(8'had, 16'h1111);
    wr(8'haa, 16'h2222);
    rd(8'had, 16'h0000);
    chk(fw[0], pat[0]);
    chk(fw[1], 16'h0000);
    chk(fw[2], 16'h7777);
    // Second reset in mid-run brings every field back to level four.
    @(posedge sys_clk);
    do_reset();
    for (int i = 0; i < 3; i++) rd(IPR_OFS[i], 16'h4444);
    close_out();
  end
endmodule
`default_nettype wire
